// [uoe_pkg.sv]
// package: register map, field layout and types of the out endpoint control block
package uoe_pkg;
  localparam logic [4:0] OFS_CSR_LO   = 5'h14;
  localparam logic [4:0] OFS_CSR_HI   = 5'h15;
  localparam logic [4:0] OFS_CNT_LO   = 5'h16;
  localparam logic [4:0] OFS_CNT_HI   = 5'h17;
  localparam logic [4:0] OFS_EP_SEL   = 5'h18;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h19;
  localparam logic [4:0] OFS_IRQ_EN   = 5'h1A;
  localparam logic [4:0] OFS_IRQ_CLR  = 5'h1B;
  localparam logic [4:0] OFS_TOGGLE   = 5'h1C;
  localparam int BIT_CLR_TOGGLE = 7;
  localparam int BIT_STALL_SENT = 6;
  localparam int BIT_SEND_STALL = 5;
  localparam int BIT_FLUSH      = 4;
  localparam int BIT_ISO_ERR    = 3;
  localparam int BIT_ISO_ISO_OVERRUN_FLAG  = 2;
  localparam int BIT_FIFO_FULL  = 1;
  localparam int BIT_PKT_READY  = 0;
  localparam int BIT_DBL_BUF    = 7;
  localparam int BIT_ISO_MODE   = 6;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int NUM_EP = 3;

  typedef struct packed {
    logic       valid;
    logic [1:0] ep;
    logic [9:0] count;
    logic       crc_err;
  } uoe_rx_pkt_t;

  typedef struct packed {
    logic       stall;
    logic       ack;
    logic       nak;
    logic [1:0] ep;
  } uoe_hs_t;
endpackage : uoe_pkg

// [uoe_ep_slot.sv]
// one out endpoint: control, status, two-slot packet count queue
`timescale 1ns/1ns
module uoe_ep_slot (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       rx_i,
  input  wire logic [9:0] rx_count_i,
  input  wire logic       rx_crc_err_i,
  input  wire logic       wr_lo_i,
  input  wire logic       wr_hi_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] csr_lo_o,
  output logic      [7:0] csr_hi_o,
  output logic      [9:0] count_o,
  output logic            stall_o,
  output logic            ack_o,
  output logic            nak_o,
  output logic            toggle_o,
  output logic            ready_evt_o,
  output logic            stall_evt_o,
  output logic            iso_overrun_flag_evt_o
);
  import uoe_pkg::*;
  logic [9:0] cnt_r [2];
  logic [1:0] err_r;
  logic [1:0] pkts_r;
  logic       dbl_r, iso_r, sstall_r, ssent_r, ovr_r, rdy_r, tog_r;
  wire  full    = dbl_r ? (pkts_r == 2'd2) : (pkts_r != 2'd0);
  wire  stalls  = sstall_r & ~iso_r;
  wire  accept  = rx_i & ~stalls & ~full;
  wire  lost    = rx_i & ~stalls & full;
  wire  clr_rdy = wr_lo_i & ~wdata_i[BIT_PKT_READY] & rdy_r;
  wire  flush   = wr_lo_i & wdata_i[BIT_FLUSH] & (pkts_r != 2'd0);
  wire  pop     = clr_rdy | flush;
  wire  [1:0] pkts_nxt = pkts_r + {1'b0, accept} - {1'b0, pop};
  assign stall_o     = rx_i & stalls;
  assign ack_o       = accept & ~iso_r;
  assign nak_o       = lost & ~iso_r;
  assign toggle_o    = tog_r;
  // a second queued packet shows as ready again right after the first pop
  // an arrival that lands while the head packet is popped also needs its own interrupt
  assign ready_evt_o = (accept & ((pkts_r == 2'd0) | (pop & (pkts_r == 2'd1))))
                     | (pop & (pkts_r == 2'd2));
  assign stall_evt_o = stall_o;
  assign iso_overrun_flag_evt_o = lost & iso_r;
  assign count_o     = rdy_r ? cnt_r[0] : 10'h000;
  assign csr_lo_o = {1'b0, ssent_r, sstall_r, 1'b0, err_r[0] & iso_r & rdy_r,
                     ovr_r, full, rdy_r};
  assign csr_hi_o = {dbl_r, iso_r, 6'h00};
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dbl_r <= 1'b0; iso_r <= 1'b0; sstall_r <= 1'b0; ssent_r <= 1'b0;
      ovr_r <= 1'b0; rdy_r <= 1'b0; tog_r <= 1'b0; pkts_r <= 2'd0;
      err_r <= 2'b00; cnt_r[0] <= 10'h000; cnt_r[1] <= 10'h000;
    end else begin
      if (wr_hi_i) begin
        dbl_r <= wdata_i[BIT_DBL_BUF];
        iso_r <= wdata_i[BIT_ISO_MODE];
      end
      if (wr_lo_i) sstall_r <= wdata_i[BIT_SEND_STALL];
      // set wins over a clear in the same cycle
      ssent_r <= stall_o | (ssent_r & ~(wr_lo_i & ~wdata_i[BIT_STALL_SENT]));
      ovr_r   <= iso_overrun_flag_evt_o | (ovr_r & ~(wr_lo_i & ~wdata_i[BIT_ISO_ISO_OVERRUN_FLAG]));
      if (wr_lo_i & wdata_i[BIT_CLR_TOGGLE]) tog_r <= 1'b0;
      else if (accept & ~iso_r) tog_r <= ~tog_r;
      pkts_r <= pkts_nxt;
      rdy_r  <= (pkts_nxt != 2'd0);
      if (pop) begin
        cnt_r[0] <= cnt_r[1];
        err_r[0] <= err_r[1];
      end
      // crc-damaged iso packets are still stored
      if (accept) begin
        if (pkts_r == 2'd0 || (pop && pkts_r == 2'd1)) begin
          cnt_r[0] <= rx_count_i;
          err_r[0] <= rx_crc_err_i & iso_r;
        end else begin
          cnt_r[1] <= rx_count_i;
          err_r[1] <= rx_crc_err_i & iso_r;
        end
      end
    end
  end
endmodule : uoe_ep_slot

// [uoe_ctrl.sv]
// top: wishbone register file and three out endpoints
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ns
// What this block does
// - writing one to clear_toggle zeroes the data toggle; the bit reads zero
// - stall_sent_flag sets on each sent stall and stays until firmware clears it
// - send_stall makes the endpoint stall; zero stops; ignored in isochronous mode
// - flush drops the next packet, resets the pointer, clears packet_ready unless a second double-buffered packet remains, self-clears
// - iso crc or stuffing error sets iso_data_error, cleared with packet_ready
// - iso packet lost to a full fifo sets iso_overrun_flag until firmware clears
// - fifo_full_status reads one at two packets double-buffered, one packet single
// - packet_ready sets with an interrupt on arrival; firmware clears after unload
// - double_buffer_enable chooses double or single buffering
// - transfer-type bit selects isochronous or bulk/interrupt
// - low six bits of buffer config read zero, writes ignored
// - ten-bit byte count split across count low and count high, valid when ready
// - bulk mode with send_stall: every out gets stall plus interrupt and flag
// - second double-buffered packet re-sets packet_ready after the first clear
// - iso packet with crc error is still stored, ready set, interrupt raised
module uoe_ctrl (
  input  wire logic                clk_i,
  input  wire logic                reset_n_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire uoe_pkg::uoe_rx_pkt_t rx_pkt_i,
  output uoe_pkg::uoe_hs_t         hs_o,
  output logic      [2:0]          toggle_o,
  output logic                     irq_o
);
  import uoe_pkg::*;
  logic [1:0]  sel_r;
  logic [2:0]  irq_stat_r, irq_en_r;
  logic        ack_r;
  logic [31:0] rdat_r;
  logic [7:0]  lo_v [NUM_EP];
  logic [7:0]  hi_v [NUM_EP];
  logic [9:0]  cnt_v [NUM_EP];
  logic [2:0]  st_v, ak_v, nk_v, rdy_e, stl_e, ovr_e;

  wire       req   = wb_cyc_i & wb_stb_i & ~ack_r;
  wire [4:0] idx   = wb_adr_i[6:2];
  wire       lane0 = wb_sel_i[0];
  wire       wr    = req & wb_we_i & lane0 & (wb_adr_i[7] == 1'b0);
  // the upper half of the window is unmapped: reads there must not alias the registers
  wire       rd    = req & ~wb_we_i & (wb_adr_i[7] == 1'b0);
  wire [1:0] cur   = (sel_r == 2'd0) ? 2'd1 : sel_r;
  wire [1:0] ci    = cur - 2'd1;
  wire [2:0] evt   = rdy_e | stl_e | ovr_e;

  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++) begin : g_ep
      wire mine = (ci == 2'(g));
      uoe_ep_slot u_ep (
        .clk_i        (clk_i),
        .reset_n_i    (reset_n_i),
        .rx_i         (rx_pkt_i.valid & (rx_pkt_i.ep == 2'(g + 1))),
        .rx_count_i   (rx_pkt_i.count),
        .rx_crc_err_i (rx_pkt_i.crc_err),
        .wr_lo_i      (wr & mine & (idx == OFS_CSR_LO)),
        .wr_hi_i      (wr & mine & (idx == OFS_CSR_HI)),
        .wdata_i      (wb_dat_i[7:0]),
        .csr_lo_o     (lo_v[g]),
        .csr_hi_o     (hi_v[g]),
        .count_o      (cnt_v[g]),
        .stall_o      (st_v[g]),
        .ack_o        (ak_v[g]),
        .nak_o        (nk_v[g]),
        .toggle_o     (toggle_o[g]),
        .ready_evt_o  (rdy_e[g]),
        .stall_evt_o  (stl_e[g]),
        .iso_overrun_flag_evt_o  (ovr_e[g])
      );
    end
  endgenerate

  assign hs_o = '{stall: |st_v, ack: |ak_v, nak: |nk_v, ep: rx_pkt_i.ep};
  assign irq_o      = |(irq_stat_r & irq_en_r);
  assign wb_ack_o   = ack_r;
  assign wb_dat_o   = rdat_r;

  wire [7:0] rsel =
    (idx == OFS_CSR_LO)   ? lo_v[ci] :
    (idx == OFS_CSR_HI)   ? hi_v[ci] :
    (idx == OFS_CNT_LO)   ? cnt_v[ci][7:0] :
    (idx == OFS_CNT_HI)   ? {6'h00, cnt_v[ci][9:8]} :
    (idx == OFS_EP_SEL)   ? {6'h00, sel_r} :
    (idx == OFS_IRQ_STAT) ? {5'h00, irq_stat_r} :
    (idx == OFS_IRQ_EN)   ? {5'h00, irq_en_r} :
    (idx == OFS_TOGGLE)   ? {5'h00, toggle_o} : 8'h00;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
      sel_r <= 2'd0;
      irq_en_r <= 3'h0;
      irq_stat_r <= 3'h0;
    end else begin
      ack_r <= req;
      rdat_r <= rd ? {24'h000000, rsel} : 32'h0000_0000;
      if (wr && idx == OFS_EP_SEL) sel_r <= wb_dat_i[1:0];
      if (wr && idx == OFS_IRQ_EN) irq_en_r <= wb_dat_i[2:0];
      // new events win over a clear in the same cycle
      irq_stat_r <= evt | (irq_stat_r &
                    ~((wr && idx == OFS_IRQ_CLR) ? wb_dat_i[2:0] : 3'h0));
    end
  end

  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  a_ack_follows: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wb_cyc_i & wb_stb_i & !wb_ack_o) |=> wb_ack_o) else $error("no ack");
  a_irq_event: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (evt[0] & irq_en_r[0]) |=> irq_o) else $error("irq missed");
  a_stall_iso: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    hs_o.stall |-> !(hi_v[rx_pkt_i.ep - 2'd1][BIT_ISO_MODE])) else $error("iso stall");
  a_stall_flag: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    st_v[0] |=> lo_v[0][BIT_STALL_SENT]) else $error("stall flag");
  a_hi_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    hi_v[0][5:0] == 6'h00) else $error("hi bits");
  a_toggle_read: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !lo_v[0][BIT_CLR_TOGGLE] && !lo_v[0][BIT_FLUSH]) else $error("wo bits");
  a_full_single: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!hi_v[0][BIT_DBL_BUF] && lo_v[0][BIT_PKT_READY]) |-> lo_v[0][BIT_FIFO_FULL])
    else $error("full single");
  wire wr_lo0 = wr & (ci == 2'd0) & (idx == OFS_CSR_LO);
  a_toggle_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wr_lo0 && wb_dat_i[BIT_CLR_TOGGLE]) |=> !toggle_o[0]) else $error("toggle kept");
  a_flush_single: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wr_lo0 && wb_dat_i[BIT_FLUSH] && !hi_v[0][BIT_DBL_BUF] && lo_v[0][BIT_PKT_READY])
    |=> !lo_v[0][BIT_PKT_READY]) else $error("flush kept packet");
  a_ready_irq: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    rdy_e[0] |=> irq_stat_r[0]) else $error("ready event lost");
  a_iso_quiet: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (rx_pkt_i.valid && rx_pkt_i.ep == 2'd1 && hi_v[0][BIT_ISO_MODE])
    |-> !(hs_o.stall || hs_o.ack || hs_o.nak)) else $error("iso handshake");
  c_second_ready: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    lo_v[0][BIT_PKT_READY] && rdy_e[0]);
  c_stall: cover property (@(posedge clk_i) disable iff (!reset_n_i) hs_o.stall);
  c_iso_overrun_flag: cover property (@(posedge clk_i) disable iff (!reset_n_i) |ovr_e);
  c_irq:   cover property (@(posedge clk_i) disable iff (!reset_n_i) irq_o);
endmodule : uoe_ctrl

// [uoe_host_model.sv]
// partner: usb host model that hands received out packets to the block
`timescale 1ns/1ns
module uoe_host_model (
  input  wire uoe_pkg::uoe_hs_t hs_i,
  input  wire logic             clk_i,
  output uoe_pkg::uoe_rx_pkt_t  rx_pkt_o,
  output logic                  stall_seen_o,
  output uoe_pkg::uoe_hs_t      hs_seen_o
);
  import uoe_pkg::*;
  initial begin
    rx_pkt_o     = '0;
    stall_seen_o = 1'b0;
    hs_seen_o    = '0;
  end
  // one packet per call; idle fields are inverted so a stale count never looks live
  task automatic send(input logic [1:0] ep, input logic [9:0] cnt, input logic crc);
    @(posedge clk_i);
    rx_pkt_o <= '{valid: 1'b1, ep: ep, count: cnt, crc_err: crc};
    @(negedge clk_i);
    stall_seen_o = hs_i.stall;
    hs_seen_o    = hs_i;
    @(posedge clk_i);
    rx_pkt_o <= '{valid: 1'b0, ep: ~ep, count: ~cnt, crc_err: ~crc};
  endtask : send
endmodule : uoe_host_model

// [uoe_ctrl_tb.sv]
// testbench: register and packet sequences for the out endpoint control block
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module uoe_ctrl_tb;
  import uoe_pkg::*;
  logic         clk_i     = 1'b0;
  logic         reset_n_i = 1'b0;
  logic         req       = 1'b0;
  logic         we        = 1'b0;
  logic [7:0]   adr       = 8'h00;
  logic [31:0]  dat       = 32'h0;
  logic [3:0]   sel       = 4'hF;
  logic [7:0]   rdat;
  logic [31:0]  wb_dat_o;
  logic         wb_ack_o;
  uoe_rx_pkt_t  rx_pkt;
  uoe_hs_t      hs_o;
  logic [2:0]   toggle_o;
  logic         irq_o;
  int           fails      = 0;
  int           n_compared = 0;
  always #25 clk_i = ~clk_i;
  uoe_ctrl i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(req), .wb_stb_i(req),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rx_pkt_i(rx_pkt), .hs_o(hs_o), .toggle_o(toggle_o), .irq_o(irq_o));
  uoe_host_model i_host (.hs_i(hs_o), .clk_i(clk_i), .rx_pkt_o(rx_pkt), .stall_seen_o(),
    .hs_seen_o());
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  // ack and read data are taken at the rising edge that samples ack high; release follows
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    req <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h0, d};
    k = 0;
    do begin @(posedge clk_i); k++; end while (wb_ack_o !== 1'b1 && k < 20);
    if (wb_ack_o !== 1'b1) begin
      fails++;
      results();
    end else begin
      rdat = wb_dat_o[7:0];
      req <= 1'b0;
    end
  endtask : xfer
  task automatic wr(input logic [4:0] o, input logic [7:0] d);
    xfer(1'b1, {1'b0, o, 2'b00}, d);
  endtask : wr
  task automatic chk_rd(input logic [4:0] o, input logic [7:0] e);
    xfer(1'b0, {1'b0, o, 2'b00}, 8'h00);
    `CHK(rdat, e)
  endtask : chk_rd
  initial begin
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 4; i++) chk_rd(5'(OFS_CSR_LO + i), REG_RESET);
    xfer(1'b0, 8'h80, 8'h00);
    `CHK(rdat, 8'h00)
    $display("test reset: done");
    wr(OFS_EP_SEL, 8'h01);
    wr(OFS_IRQ_EN, 8'h07);
    i_host.send(2'd1, 10'h2A5, 1'b0);
    chk_rd(OFS_CSR_LO, 8'h03);
    chk_rd(OFS_CNT_LO, 8'hA5);
    chk_rd(OFS_CNT_HI, 8'h02);
    `CHK(i_host.hs_seen_o, 5'b01001)
    `CHK(irq_o, 1'b1)
    i_host.send(2'd1, 10'h1FF, 1'b0);
    `CHK(i_host.hs_seen_o, 5'b00101)
    chk_rd(OFS_CNT_LO, 8'hA5);
    chk_rd(OFS_IRQ_STAT, 8'h01);
    chk_rd(OFS_TOGGLE, 8'h01);
    wr(OFS_CSR_LO, 8'h00);
    wr(OFS_IRQ_CLR, 8'h07);
    chk_rd(OFS_CNT_LO, 8'h00);
    `CHK(irq_o, 1'b0)
    $display("test single packet: done");
    wr(OFS_CSR_HI, 8'hBF);
    chk_rd(OFS_CSR_HI, 8'h80);
    xfer(1'b0, {1'b1, OFS_CSR_HI, 2'b00}, 8'h00);
    `CHK(rdat, 8'h00)
    xfer(1'b1, {1'b1, OFS_CSR_HI, 2'b00}, 8'h40);
    sel <= 4'hE;
    wr(OFS_CSR_HI, 8'h40);
    sel <= 4'hF;
    chk_rd(OFS_CSR_HI, 8'h80);
    i_host.send(2'd1, 10'h005, 1'b0);
    i_host.send(2'd1, 10'h007, 1'b0);
    chk_rd(OFS_CSR_LO, 8'h03);
    wr(OFS_IRQ_CLR, 8'h07);
    wr(OFS_CSR_LO, 8'h00);
    chk_rd(OFS_CSR_LO, 8'h01);
    chk_rd(OFS_CNT_LO, 8'h07);
    `CHK(irq_o, 1'b1)
    wr(OFS_CSR_LO, 8'h11);
    chk_rd(OFS_CSR_LO, 8'h00);
    `CHK(toggle_o[0], 1'b1)
    wr(OFS_CSR_LO, 8'h80);
    `CHK(toggle_o, 3'b000)
    chk_rd(OFS_CSR_LO, 8'h00);
    $display("test double buffer, flush, toggle: done");
    wr(OFS_CSR_LO, 8'h20);
    wr(OFS_IRQ_CLR, 8'h07);
    i_host.send(2'd1, 10'h003, 1'b0);
    `CHK(i_host.stall_seen_o, 1'b1)
    chk_rd(OFS_CSR_LO, 8'h60);
    `CHK(irq_o, 1'b1)
    wr(OFS_CSR_LO, 8'h40);
    i_host.send(2'd1, 10'h003, 1'b0);
    `CHK(i_host.stall_seen_o, 1'b0)
    `CHK(i_host.hs_seen_o, 5'b01001)
    chk_rd(OFS_CSR_LO, 8'h41);
    wr(OFS_CSR_LO, 8'h00);
    chk_rd(OFS_CSR_LO, 8'h00);
    $display("test stall: done");
    wr(OFS_CSR_HI, 8'h40);
    wr(OFS_CSR_LO, 8'h20);
    i_host.send(2'd1, 10'h009, 1'b1);
    `CHK(i_host.stall_seen_o, 1'b0)
    chk_rd(OFS_CSR_LO, 8'h2B);
    i_host.send(2'd1, 10'h004, 1'b0);
    chk_rd(OFS_CSR_LO, 8'h2F);
    wr(OFS_CSR_LO, 8'h20);
    chk_rd(OFS_CSR_LO, 8'h20);
    $display("test isochronous: done");
    wr(OFS_EP_SEL, 8'h02);
    chk_rd(OFS_EP_SEL, 8'h02);
    chk_rd(OFS_CSR_HI, 8'h00);
    chk_rd(OFS_CSR_LO, 8'h00);
    i_host.send(2'd2, 10'h011, 1'b0);
    chk_rd(OFS_CSR_LO, 8'h03);
    chk_rd(OFS_CNT_LO, 8'h11);
    chk_rd(OFS_IRQ_STAT, 8'h03);
    wr(OFS_EP_SEL, 8'h01);
    chk_rd(OFS_CSR_HI, 8'h40);
    chk_rd(OFS_CSR_LO, 8'h20);
    $display("test endpoint select: done");
    results();
  end
endmodule : uoe_ctrl_tb
